// ---- scd_pkg.sv ----
// constants shared by the scan-chain and power-down block
// assumes one 20 MHz clock; every pin is already synchronous to it
package scd_pkg;
    localparam int JK_CELLS = 20;
    localparam int JK_BANK_A = 10;
    localparam int OUT_CELLS = 16;
    localparam int IN_CELLS = 16;
    localparam int IN_BANK = 8;
    localparam int CHAIN_LEN = JK_CELLS + OUT_CELLS;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 1;
    localparam int CLOCK_HZ = 20000000;
    localparam logic [JK_CELLS-1:0] JK_RESET = 20'h00000;
    localparam logic [OUT_CELLS-1:0] OUT_RESET = 16'h0000;
    localparam logic [IN_CELLS-1:0] IN_RESET = 16'h0000;
    localparam logic [OUT_CELLS-1:0] OE_OFF = 16'h0000;
    typedef enum logic [1:0] {MODE_NORMAL, MODE_SCAN, MODE_SLEEP} scd_mode_e;
endpackage

// ---- scd_stream_if.sv ----
// valid/ready word carrier between the block's own modules
// assumes both ends share one clock
interface scd_stream_if #(parameter int WIDTH = 1);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ---- scd_fifo.sv ----
// synchronous fifo with parameterised width and depth
// assumes a single clock and a synchronous active-low reset
module scd_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input wire logic clock, // system clock
    input wire logic resetn, // synchronous reset, active low
    scd_stream_if.snk wr, // filling side
    scd_stream_if.src rd // draining side
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    logic push;
    logic pop;

    assign wr.ready = (count_reg != FULL_COUNT);
    assign rd.valid = (count_reg != '0);
    assign rd.data = mem[rd_ptr_reg];
    assign push = wr.valid & wr.ready;
    assign pop = rd.valid & rd.ready;

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        return (p == LAST_SLOT) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_reg] <= wr.data;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wrap_inc(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= wrap_inc(rd_ptr_reg);
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// ---- scd_scan_power.sv ----
// scan chain, freeze and output control of the programmable logic core
// assumes all pins, clock pins included, are synchronous to clock;
// clock pins are sampled and their rising edges become enables
module scd_scan_power
    import scd_pkg::*;
#(
    parameter int NJK = JK_CELLS,
    parameter int NOUT = OUT_CELLS,
    parameter int NIN = IN_CELLS,
    parameter int NJKA = JK_BANK_A,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clock, // 20 MHz system clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic scan_mode_select, // 1 selects scan mode
    input wire logic scan_serial_in, // chain input, float control in sleep
    input wire logic scan_shift_clock_pin, // scan clock pin level
    input wire logic sleep_freeze_pin, // 1 freezes the device
    input wire logic security_fuse, // copy protection fuse state
    input wire logic input_bank_a_register_clock, // input cells 0..7 clock
    input wire logic input_bank_b_register_clock, // input cells 8..15 clock
    input wire logic [1:0] output_register_clocks, // output cell bank clocks
    input wire logic buried_bank_clock_two, // shared clock, JK bank B
    input wire logic [NJKA-1:0] jk_array_clock_terms, // internal clock terms
    input wire logic [NIN-1:0] in_pin_data, // data into input cells
    input wire logic [NJK-1:0] jk_set_terms, // J term per JK cell
    input wire logic [NJK-1:0] jk_reset_terms, // K term per JK cell
    input wire logic cell_force_high, // shared preset, JK bank B
    input wire logic [NJKA-1:0] cell_force_low, // clears, JK bank A
    input wire logic [NOUT-1:0] out_cell_data, // data into output cells
    input wire logic [NOUT-1:0] out_bypass_fuse, // 1 bypasses output cell
    input wire logic [NOUT-1:0] out_enable_terms, // per-pin output enables
    input wire logic result_ready, // drain side may take a result bit
    output logic [NOUT-1:0] io_out, // pin output values
    output logic [NOUT-1:0] io_oe, // pin output enables, high drives
    output logic chain_serial_out, // inverted last chain cell
    output logic [NIN-1:0] in_cell_q, // input cell contents
    output logic [NJK-1:0] jk_cell_q, // buried JK cell contents
    output logic [NOUT-1:0] out_cell_q, // output cell contents
    output logic scan_active, // block is in scan mode
    output logic frozen, // block is in power-down
    output logic result_valid, // a captured result bit waits
    output logic result_data, // oldest captured result bit
    output logic shift_stalled // a scan edge was dropped, fifo full
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [NJK-1:0] jk_reg;
    logic [NJK-1:0] jk_next;
    logic [NOUT-1:0] out_reg;
    logic [NOUT-1:0] out_next;
    logic [NIN-1:0] in_reg;
    logic [NIN-1:0] in_next;
    logic [NOUT-1:0] io_out_reg;
    logic [NOUT-1:0] io_oe_reg;
    logic chain_out_reg;
    logic stall_reg;
    scd_mode_e mode_reg;
    scd_mode_e mode_next;

    // previous samples of every clock pin, for rising-edge enables
    logic scan_clk_prev_reg;
    logic in_a_prev_reg;
    logic in_b_prev_reg;
    logic [1:0] out_clk_prev_reg;
    logic jk_b_prev_reg;
    logic [NJKA-1:0] jk_a_prev_reg;

    logic scan_edge;
    logic shift_en;
    logic in_a_edge;
    logic in_b_edge;
    logic [1:0] out_edge;
    logic jk_b_edge;
    logic [NJKA-1:0] jk_a_edge;
    logic [NJKA-1:0] jk_a_gated;

    scd_stream_if #(.WIDTH(FIFO_WIDTH)) push_if ();
    scd_stream_if #(.WIDTH(FIFO_WIDTH)) pop_if ();

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic rise(input logic prev, input logic now);
        return now & ~prev;
    endfunction

    function automatic logic jk_step(input logic q, input logic j,
                                     input logic k);
        logic r;
        r = q;
        case ({j, k})
            2'b10: r = 1'b1;
            2'b01: r = 1'b0;
            2'b11: r = ~q;
            default: r = q;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // mode selection
    // ----------------------------------------------------------------
    // freeze outranks scan; the tester is expected to keep scan low
    // while frozen, so this order only matters for a misbehaving tester
    always_comb begin
        if (sleep_freeze_pin) begin
            mode_next = MODE_SLEEP;
        end else if (scan_mode_select) begin
            mode_next = MODE_SCAN;
        end else begin
            mode_next = MODE_NORMAL;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            mode_reg <= MODE_NORMAL;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // ----------------------------------------------------------------
    // clock pin edges
    // ----------------------------------------------------------------
    // samples keep running while frozen so that no stale edge fires on
    // wake; edges that do arrive while frozen are simply dropped
    always_ff @(posedge clock) begin
        if (!resetn) begin
            scan_clk_prev_reg <= 1'b0;
            in_a_prev_reg <= 1'b0;
            in_b_prev_reg <= 1'b0;
            out_clk_prev_reg <= 2'b00;
            jk_b_prev_reg <= 1'b0;
            jk_a_prev_reg <= '0;
        end else begin
            scan_clk_prev_reg <= scan_shift_clock_pin;
            in_a_prev_reg <= input_bank_a_register_clock;
            in_b_prev_reg <= input_bank_b_register_clock;
            out_clk_prev_reg <= output_register_clocks;
            jk_b_prev_reg <= buried_bank_clock_two;
            jk_a_prev_reg <= jk_array_clock_terms;
        end
    end

    assign scan_edge = rise(scan_clk_prev_reg, scan_shift_clock_pin);
    assign in_a_edge = rise(in_a_prev_reg, input_bank_a_register_clock);
    assign in_b_edge = rise(in_b_prev_reg, input_bank_b_register_clock);
    assign out_edge[0] = rise(out_clk_prev_reg[0], output_register_clocks[0]);
    assign out_edge[1] = rise(out_clk_prev_reg[1], output_register_clocks[1]);
    assign jk_b_edge = rise(jk_b_prev_reg, buried_bank_clock_two);
    assign jk_a_edge = jk_array_clock_terms & ~jk_a_prev_reg;
    // internally made clock-array terms are stopped while frozen
    assign jk_a_gated = sleep_freeze_pin ? '0 : jk_a_edge;

    // a shift needs room for the outgoing bit; a full fifo drops the edge
    assign shift_en = (mode_next == MODE_SCAN) && scan_edge
                      && push_if.ready;

    // ----------------------------------------------------------------
    // next cell values
    // ----------------------------------------------------------------
    always_comb begin
        jk_next = jk_reg;
        out_next = out_reg;
        in_next = in_reg;
        case (mode_next)
            MODE_SCAN: begin
                // functional inputs, forces and normal clocks are all cut
                if (shift_en) begin
                    jk_next = {jk_reg[NJK-2:0], scan_serial_in};
                    out_next = {out_reg[NOUT-2:0], jk_reg[NJK-1]};
                end
            end
            MODE_NORMAL: begin
                // bank a steps on its own terms, bank b on one shared clock
                for (int i = 0; i < NJKA; i++) begin
                    if (jk_a_gated[i]) begin
                        jk_next[i] = jk_step(jk_reg[i], jk_set_terms[i],
                                             jk_reset_terms[i]);
                    end
                end
                for (int i = NJKA; i < NJK; i++) begin
                    if (jk_b_edge) begin
                        jk_next[i] = jk_step(jk_reg[i], jk_set_terms[i],
                                             jk_reset_terms[i]);
                    end
                end
                for (int i = 0; i < NJKA; i++) begin
                    if (cell_force_low[i]) begin
                        jk_next[i] = 1'b0;
                    end
                end
                if (cell_force_high) begin
                    jk_next[NJK-1:NJKA] = '1;
                end
                for (int i = 0; i < NOUT; i++) begin
                    if (out_edge[(i < IN_BANK) ? 0 : 1]) begin
                        out_next[i] = out_cell_data[i];
                    end
                end
                for (int i = 0; i < NIN; i++) begin
                    if ((i < IN_BANK) ? in_a_edge : in_b_edge) begin
                        in_next[i] = in_pin_data[i];
                    end
                end
            end
            default: begin
                // frozen: every cell holds, whatever the other inputs do
                jk_next = jk_reg;
                out_next = out_reg;
                in_next = in_reg;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // cell registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            jk_reg <= JK_RESET;
            out_reg <= OUT_RESET;
            in_reg <= IN_RESET;
        end else begin
            jk_reg <= jk_next;
            out_reg <= out_next;
            in_reg <= in_next;
        end
    end

    // ----------------------------------------------------------------
    // pins
    // ----------------------------------------------------------------
    // pin values follow the next cell state, inverted in scan mode, bar bypassed pins in normal mode,
    // so a shifted bit is visible on the edge right after its scan clock edge was seen
    always_ff @(posedge clock) begin
        if (!resetn) begin
            io_out_reg <= OUT_RESET;
            chain_out_reg <= 1'b1;
        end else begin
            case (mode_next)
                MODE_SCAN: begin
                    io_out_reg <= ~out_next;
                    chain_out_reg <= ~out_next[NOUT-1];
                end
                MODE_NORMAL: begin
                    for (int i = 0; i < NOUT; i++) begin
                        io_out_reg[i] <= out_bypass_fuse[i] ?
                                         out_cell_data[i] : out_next[i];
                    end
                    chain_out_reg <= ~out_next[NOUT-1];
                end
                default: begin
                    io_out_reg <= io_out_reg;
                    chain_out_reg <= chain_out_reg;
                end
            endcase
        end
    end

    // enables come only from the programmed terms, plus the disable term
    always_ff @(posedge clock) begin
        if (!resetn) begin
            io_oe_reg <= OE_OFF;
        end else if (sleep_freeze_pin && scan_serial_in) begin
            io_oe_reg <= OE_OFF;
        end else if (sleep_freeze_pin) begin
            io_oe_reg <= io_oe_reg;
        end else begin
            io_oe_reg <= out_enable_terms;
        end
    end

    // ----------------------------------------------------------------
    // result capture
    // ----------------------------------------------------------------
    // every shift pushes the bit leaving the chain, still inverted, so a
    // tester may collect results without sampling the pin at speed;
    // the first CHAIN_LEN bits after a load are old content
    assign push_if.valid = (mode_next == MODE_SCAN) && scan_edge;
    assign push_if.data = ~out_reg[NOUT-1];
    assign pop_if.ready = result_ready;

    scd_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(DEPTH)
    ) u_result_fifo (
        .clock(clock),
        .resetn(resetn),
        .wr(push_if),
        .rd(pop_if)
    );

    // sticky until reset: a dropped edge breaks the chain position count
    always_ff @(posedge clock) begin
        if (!resetn) begin
            stall_reg <= 1'b0;
        end else if (push_if.valid && !push_if.ready) begin
            stall_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign io_out = io_out_reg;
    assign io_oe = io_oe_reg;
    assign chain_serial_out = chain_out_reg;
    assign in_cell_q = in_reg;
    assign jk_cell_q = jk_reg;
    assign out_cell_q = out_reg;
    assign scan_active = (mode_reg == MODE_SCAN);
    assign frozen = (mode_reg == MODE_SLEEP);
    assign result_valid = pop_if.valid;
    assign result_data = pop_if.data[0];
    assign shift_stalled = stall_reg;

    // the fuse only guards readback of the programming, never the chain
    logic unused_fuse;
    assign unused_fuse = security_fuse;
endmodule

// ---- scd_scan_power_chk.sv ----
// assertions on the scan, freeze and result ports of the scan block
// assumes one clock domain with a synchronous active-low reset
module scd_scan_power_chk #(
    parameter int NJK = 20,
    parameter int NOUT = 16,
    parameter int NIN = 16
) (
    input wire logic clock, // system clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic scan_mode_select, // scan mode pin
    input wire logic scan_serial_in, // chain input
    input wire logic scan_shift_clock_pin, // scan clock pin
    input wire logic sleep_freeze_pin, // freeze pin
    input wire logic [NOUT-1:0] out_enable_terms, // pin enable terms
    input wire logic [NOUT-1:0] io_out, // pin values
    input wire logic [NOUT-1:0] io_oe, // pin enables
    input wire logic chain_serial_out, // serial out
    input wire logic [NIN-1:0] in_cell_q, // input cells
    input wire logic [NJK-1:0] jk_cell_q, // buried cells
    input wire logic [NOUT-1:0] out_cell_q, // output cells
    input wire logic scan_active, // scan mode flag
    input wire logic result_valid, // result bit waiting
    input wire logic shift_stalled // dropped scan edge
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    property p_pins;
        $past(resetn) && $past(scan_active) && scan_active
            && $stable(out_cell_q)
        |-> io_out == ~out_cell_q && chain_serial_out == ~out_cell_q[NOUT-1];
    endproperty
    a_pins: assert property (p_pins) else $error("scan pins bad");

    property p_shift;
        $past(resetn) && $past(scan_mode_select) && !$past(sleep_freeze_pin)
            && ($changed(jk_cell_q) || $changed(out_cell_q))
        |-> jk_cell_q == {$past(jk_cell_q[NJK-2:0]), $past(scan_serial_in)}
            && out_cell_q == {$past(out_cell_q[NOUT-2:0]),
            $past(jk_cell_q[NJK-1])};
    endproperty
    a_shift: assert property (p_shift) else $error("chain shift bad");

    property p_clock;
        $past(resetn) && $past(resetn, 2) && $past(scan_mode_select)
            && !($past(scan_shift_clock_pin) && !$past(scan_shift_clock_pin, 2))
        |-> $stable(jk_cell_q) && $stable(out_cell_q);
    endproperty
    a_clock: assert property (p_clock) else $error("cell moved");

    property p_push;
        $past(resetn) && $past(scan_mode_select) && !$past(sleep_freeze_pin)
            && $changed(jk_cell_q)
        |-> result_valid;
    endproperty
    a_push: assert property (p_push) else $error("no result");

    property p_stall;
        $rose(shift_stalled) |-> $stable(jk_cell_q) && $stable(out_cell_q);
    endproperty
    a_stall: assert property (p_stall) else $error("stall moved");

    property p_freeze;
        $past(resetn) && $past(sleep_freeze_pin)
        |-> $stable(jk_cell_q) && $stable(out_cell_q) && $stable(in_cell_q)
            && $stable(io_out);
    endproperty
    a_freeze: assert property (p_freeze) else $error("lost state");

    property p_float;
        sleep_freeze_pin && scan_serial_in |=> io_oe == '0;
    endproperty
    a_float: assert property (p_float) else $error("not floated");

    property p_oe;
        !sleep_freeze_pin |=> io_oe == $past(out_enable_terms);
    endproperty
    a_oe: assert property (p_oe) else $error("enable bad");
endmodule

bind scd_scan_power scd_scan_power_chk #(.NJK(NJK), .NOUT(NOUT), .NIN(NIN))
    i_scd_scan_power_chk (.clock, .resetn, .scan_mode_select,
    .scan_serial_in, .scan_shift_clock_pin, .sleep_freeze_pin,
    .out_enable_terms, .io_out, .io_oe, .chain_serial_out, .in_cell_q,
    .jk_cell_q, .out_cell_q, .scan_active, .result_valid, .shift_stalled);

// ---- scd_tester.sv ----
// tester model: scan clock and serial data driver plus result drain
// assumes the block samples its pins on the rising edge of clock
module scd_tester (
    input wire logic clock, // system clock
    input wire logic result_valid, // result bit waiting
    input wire logic result_data, // result bit
    output logic scan_shift_clock_pin, // scan clock, low between bits
    output logic scan_serial_in, // serial data into the chain
    output logic result_ready // drain accepts
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drain_en = 1'b1;
    logic got[$];
    assign result_ready = drain_en;
    initial begin
        scan_shift_clock_pin = 1'b0;
        scan_serial_in = 1'b0;
    end
    // kept as captured: inverted, oldest first
    always @(posedge clock) begin
        if (result_valid && result_ready) begin
            got.push_back(result_data);
        end
    end
    task automatic shift(input logic b);
        @(posedge clock);
        #2;
        scan_serial_in = b;
        scan_shift_clock_pin = 1'b1;
        @(posedge clock);
        #2;
        scan_shift_clock_pin = 1'b0;
        // released data line shows the inverse, never a stale copy
        scan_serial_in = ~b;
        @(posedge clock);
        #2;
    endtask
    task automatic hold_si(input logic b);
        scan_serial_in = b;
    endtask
endmodule

// ---- scd_scan_power_tb.sv ----
// self-checking bench for the scan chain and freeze block
// assumes the tester model drives the scan clock, serial data and drain
module scd_scan_power_tb;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(nm, ex, sn) begin checked++; if ((sn) !== (ex)) begin \
    num_errors++; $display("wrong value %s exp %h got %h", nm, ex, sn); end end
    logic clock = 0, resetn = 0, scan_mode_select = 0, sleep_freeze_pin = 0;
    logic security_fuse = 0, input_bank_a_register_clock = 0;
    logic buried_bank_clock_two = 0, cell_force_high = 0;
    logic input_bank_b_register_clock = 0;
    logic [1:0] output_register_clocks = 0;
    logic [9:0] jk_array_clock_terms = 0, cell_force_low = 0;
    logic [15:0] in_pin_data = 0, out_cell_data = 0, out_bypass_fuse = 0;
    logic [15:0] out_enable_terms = 0, io_out, io_oe, in_cell_q, out_cell_q;
    logic [19:0] jk_set_terms = 0, jk_reset_terms = 0, jk_cell_q;
    logic scan_serial_in, scan_shift_clock_pin, result_ready, chain_serial_out;
    logic scan_active, frozen, result_valid, result_data, shift_stalled;
    int num_errors = 0, checked = 0;
    logic [15:0] exp_v = 16'h1234;

    // ----------------------------------------
    // design and tester
    // ----------------------------------------
    scd_scan_power i_scd_scan_power (.clock, .resetn, .scan_mode_select,
        .scan_serial_in, .scan_shift_clock_pin, .sleep_freeze_pin,
        .security_fuse, .input_bank_a_register_clock,
        .input_bank_b_register_clock, .output_register_clocks,
        .buried_bank_clock_two, .jk_array_clock_terms, .in_pin_data,
        .jk_set_terms, .jk_reset_terms, .cell_force_high, .cell_force_low,
        .out_cell_data, .out_bypass_fuse, .out_enable_terms, .result_ready,
        .io_out, .io_oe, .chain_serial_out, .in_cell_q, .jk_cell_q,
        .out_cell_q, .scan_active, .frozen, .result_valid, .result_data,
        .shift_stalled);
    scd_tester i_scd_tester (.clock, .result_valid, .result_data,
        .scan_shift_clock_pin, .scan_serial_in, .result_ready);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic end_sim;
        if (num_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task automatic shifts(input int n, input logic b);
        repeat (n) i_scd_tester.shift(b);
    endtask
    task automatic wait_got(input int n);
        for (int i = 0; i < 40 && i_scd_tester.got.size() < n; i++) cyc(1);
        if (i_scd_tester.got.size() < n) begin
            num_errors++;
            end_sim;
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        `CHK("jk", 20'h00000, jk_cell_q)
        `CHK("out", 16'h0000, out_cell_q)
        `CHK("in", 16'h0000, in_cell_q)
        `CHK("sout", 1'b1, chain_serial_out)
    endtask
    task automatic t_scan;
        security_fuse = 1'b1;
        out_bypass_fuse = 16'hFFFF;
        out_enable_terms = 16'hFFFF;
        scan_mode_select = 1'b1;
        cyc(2);
        `CHK("scan", 1'b1, scan_active)
        // the output and JK clocks, both forces and the JK and output data inputs try to move the cells
        cell_force_high = 1'b1;
        cell_force_low = 10'h3FF;
        out_cell_data = 16'hFFFF;
        jk_set_terms = 20'hFFFFF;
        output_register_clocks = 2'b11;
        buried_bank_clock_two = 1'b1;
        jk_array_clock_terms = 10'h3FF;
        cyc(2);
        `CHK("jk", 20'h00000, jk_cell_q)
        `CHK("out", 16'h0000, out_cell_q)
        shifts(1, 1'b1);
        shifts(20, 1'b0);
        `CHK("pins21", 16'hFFFE, io_out)
        shifts(15, 1'b0);
        `CHK("pins36", 16'h7FFF, io_out)
        `CHK("sout36", 1'b0, chain_serial_out)
        `CHK("jk36", 20'h00000, jk_cell_q)
        `CHK("oe", 16'hFFFF, io_oe)
        wait_got(36);
        `CHK("stale", 36, i_scd_tester.got.size())
        foreach (i_scd_tester.got[i])
            `CHK("stale", 1'b1, i_scd_tester.got[i])
        out_enable_terms = 16'h00FF;
        cyc(2);
        `CHK("oe", 16'h00FF, io_oe)
    endtask
    task automatic t_exit;
        cell_force_high = 1'b0;
        cell_force_low = 10'h000;
        output_register_clocks = 2'b00;
        buried_bank_clock_two = 1'b0;
        jk_array_clock_terms = 10'h000;
        cyc(1);
        scan_mode_select = 1'b0;
        out_cell_data = 16'hA5A5;
        cyc(2);
        `CHK("out", 16'h8000, out_cell_q)
        `CHK("scan", 1'b0, scan_active)
        `CHK("jk", 20'h00000, jk_cell_q)
        `CHK("pins", 16'hA5A5, io_out)
        out_bypass_fuse = 16'h0000;
        out_cell_data = exp_v;
        output_register_clocks = 2'b11;
        cyc(2);
        `CHK("out", exp_v, out_cell_q)
        `CHK("pins", exp_v, io_out)
        jk_array_clock_terms = 10'h001;
        cyc(2);
        `CHK("jk", 20'h00001, jk_cell_q)
        output_register_clocks = 2'b00;
        jk_array_clock_terms = 10'h000;
        scan_mode_select = 1'b1;
        i_scd_tester.got.delete();
        cyc(2);
        shifts(16, 1'b0);
        wait_got(16);
        for (int i = 0; i < 16; i++)
            `CHK("res", ~exp_v[15-i], i_scd_tester.got[i])
    endtask
    task automatic t_freeze;
        scan_mode_select = 1'b0;
        in_pin_data = 16'h5AC3;
        input_bank_a_register_clock = 1'b1;
        input_bank_b_register_clock = 1'b1;
        cyc(2);
        input_bank_a_register_clock = 1'b0;
        input_bank_b_register_clock = 1'b0;
        cyc(1);
        out_enable_terms = 16'hFFFF;
        i_scd_tester.hold_si(1'b1);
        sleep_freeze_pin = 1'b1;
        cyc(2);
        `CHK("oe", 16'h0000, io_oe)
        `CHK("frozen", 1'b1, frozen)
        in_pin_data = 16'hFFFF;
        jk_array_clock_terms = 10'h3FF;
        cell_force_high = 1'b1;
        out_cell_data = 16'hFFFF;
        cyc(2);
        `CHK("jk", 20'h10000, jk_cell_q)
        `CHK("in", 16'h5AC3, in_cell_q)
        `CHK("out", 16'h0000, out_cell_q)
        jk_array_clock_terms = 10'h000;
        cell_force_high = 1'b0;
        i_scd_tester.hold_si(1'b0);
        cyc(1);
        sleep_freeze_pin = 1'b0;
        cyc(2);
        `CHK("oe", 16'hFFFF, io_oe)
    endtask
    task automatic t_stall;
        scan_mode_select = 1'b1;
        i_scd_tester.drain_en = 1'b0;
        i_scd_tester.got.delete();
        cyc(2);
        shifts(17, 1'b1);
        `CHK("jk", 20'h0FFFF, jk_cell_q)
        `CHK("stall", 1'b1, shift_stalled)
        `CHK("valid", 1'b1, result_valid)
        i_scd_tester.drain_en = 1'b1;
        wait_got(16);
        `CHK("count", 16, i_scd_tester.got.size())
        // only a reset clears the sticky stall flag
        resetn = 1'b0;
        cyc(2);
        resetn = 1'b1;
        cyc(1);
        t_reset;
        `CHK("stall", 1'b0, shift_stalled)
    endtask

    initial begin
        forever #25 clock = ~clock;
    end
    initial begin
        repeat (5000) @(posedge clock);
        num_errors++;
        end_sim;
    end
    initial begin
        repeat (12) @(posedge clock);
        #2;
        resetn = 1'b1;
        cyc(1);
        t_reset;
        t_scan;
        t_exit;
        t_freeze;
        t_stall;
        end_sim;
    end
endmodule
